// file: bench/ecp_periph_model.sv
// ecp_periph_model.sv - behavioural peripheral at the far end of the port
// assumes host pins change at clock edges; slow adds wait cycles
`timescale 1ns/100ps
module ecp_periph_model (
  // clock
  input wire clock,
  // host driven pins
  input wire [7:0] pdOut,
  input wire pdOeN,
  input wire strobeN,
  input wire autoFdN,
  input wire initN,
  input wire selectInN,
  // peripheral driven pins
  output wire [7:0] pdIn,
  output logic ackN = 1'b1,
  output logic busy = 1'b0,
  output logic paperError = 1'b1,
  // bench side
  input wire [1:0] slow,
  output logic gotValid = 1'b0,
  output logic [8:0] gotWord
);
  logic [8:0] revQ[$];
  logic [8:0] w = 9'h000;
  logic drive = 1'b0;
  logic [7:0] noise = 8'h3c;
  // released bus shows a changing pattern
  assign pdIn = drive ? w[7:0] : noise;
  always @(posedge clock) noise <= ~noise + 8'h01;
  always begin
    @(posedge clock);
    if (initN != paperError) begin
      repeat (slow) @(posedge clock);
      paperError <= initN;
      busy <= 1'b0;
    end else if (initN && !strobeN && !pdOeN) begin
      gotWord <= {!autoFdN, pdOut};
      gotValid <= 1'b1;
      @(posedge clock);
      gotValid <= 1'b0;
      busy <= 1'b1;
      while (!strobeN) @(posedge clock);
      repeat (slow) @(posedge clock);
      busy <= 1'b0;
    end else if (!initN && !paperError && !autoFdN && selectInN && revQ.size() > 0) begin
      busy <= !revQ[0][8];
      w <= revQ.pop_front();
      drive <= 1'b1;
      repeat (slow + 1) @(posedge clock);
      ackN <= 1'b0;
      while (!autoFdN) @(posedge clock);
      drive <= 1'b0;
      ackN <= 1'b1;
    end
  end
endmodule

// file: bench/ecp_pp_sva.sv
// ecp_pp_sva.sv - assertions on the ecp parallel port pins
// assumes binding to ecp_parallel_port; mode tracked from host writes
`timescale 1ns/100ps
module ecp_pp_sva (
  // clock and reset
  input wire clock,
  input wire reset,
  // host side
  input wire [10:0] ioAddr,
  input wire ioWr,
  input wire ioRd,
  input wire [7:0] ioWdata,
  input wire [7:0] ioRdata_r,
  input wire dmaReq,
  input wire dmaAckN,
  input wire [2:0] irqSelect,
  input wire [2:0] dmaSelect,
  // printer pins
  input wire pdOeN,
  input wire strobeN,
  input wire initN,
  input wire selectInN,
  input wire busy,
  input wire paperError
);
  reg [2:0] mode_r;
  reg dma_enable_bit_r;
  wire hostRd = ioRd && dmaAckN;
  wire ecpMode = mode_r == 3'h3;
  wire fifoMode = mode_r[2:1] == 2'b01;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r <= 3'h0;
      dma_enable_bit_r <= 1'b0;
    end else if (ioWr && dmaAckN && ioAddr == 11'h402) begin
      mode_r <= ioWdata[7:5];
      dma_enable_bit_r <= ioWdata[3];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_selIn; ecpMode && $stable(mode_r) |-> selectInN; endproperty
  a_selIn: assert property (p_selIn) else $error("select in asserted in ecp mode");
  property p_status;
    hostRd && ioAddr == 11'h001 |=> ioRdata_r[2:0] == 3'h0 ##1 ($past(ioRd) || $stable(ioRdata_r));
  endproperty
  a_status: assert property (p_status) else $error("status read wrong or not held");
  property p_cfgB; hostRd && ioAddr == 11'h401 && mode_r == 3'h7 |=> ioRdata_r[5:0] == $past({irqSelect, dmaSelect});
  endproperty
  a_cfgB: assert property (p_cfgB) else $error("config b selections wrong");
  property p_revOrder; ecpMode && $fell(initN) |-> pdOeN; endproperty
  a_revOrder: assert property (p_revOrder) else $error("reverse asked while driving bus");
  property p_takeBus; ecpMode && $fell(pdOeN) |-> initN && $past(paperError, 2); endproperty
  a_takeBus: assert property (p_takeBus) else $error("bus taken before acknowledge");
  property p_strobe; fifoMode && $fell(strobeN) |-> !busy && !$past(busy, 2); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe while peripheral busy");
  property p_strobeHold; fifoMode && !strobeN && !busy && !$past(busy) |=> !strobeN; endproperty
  a_strobeHold: assert property (p_strobeHold) else $error("strobe released early");
  property p_dma; dmaReq |-> dma_enable_bit_r && fifoMode; endproperty
  a_dma: assert property (p_dma) else $error("dma request outside dma modes");
  c_fwd: cover property (ecpMode && $fell(strobeN));
  c_rev: cover property (ecpMode && $fell(initN));
  c_dma: cover property (dmaReq && !dmaAckN && ioWr);
endmodule
bind ecp_parallel_port ecp_pp_sva chk_u (.clock(clock), .reset(reset), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
  .ioWdata(ioWdata), .ioRdata_r(ioRdata_r), .dmaReq(dmaReq), .dmaAckN(dmaAckN), .irqSelect(irqSelect),
  .dmaSelect(dmaSelect), .pdOeN(pdOeN), .strobeN(strobeN), .initN(initN), .selectInN(selectInN), .busy(busy),
  .paperError(paperError));

// file: bench/tb.sv
// tb.sv - self-checking bench for the ecp parallel port
// assumes the design and the peripheral model are compiled first
`timescale 1ns/100ps
module tb;
  logic clock, reset, ioWr, ioRd, dmaAckN, faultN, rdSeen;
  logic [10:0] ioAddr;
  logic [7:0] ioWdata, b;
  logic [7:0] mem[16];
  logic [7:0] md[2] = '{8'h54, 8'h74};
  logic [2:0] irqSelect, dmaSelect;
  logic [1:0] slow;
  wire [7:0] ioRdata_r, pdIn, pdOut_r;
  wire dmaReq, irqLine, pdOeN, strobeN, autoFdN, initN, selectInN, ackN, busy, paperError, gotValid;
  wire [8:0] gotWord;
  logic [8:0] expFwd[$];
  logic [7:0] expRd[$];
  logic [31:0] seed = 32'hf1a4ed87;
  int err_total = 0, n_compared = 0, cycles = 0, i, j, k;
  ecp_parallel_port dut_u (.clock(clock), .reset(reset), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWdata(ioWdata), .ioRdata_r(ioRdata_r), .dmaReq(dmaReq), .dmaAckN(dmaAckN), .irqSelect(irqSelect),
    .dmaSelect(dmaSelect), .irqLine(irqLine), .pdIn(pdIn), .pdOut_r(pdOut_r), .pdOeN(pdOeN), .strobeN(strobeN),
    .autoFdN(autoFdN), .initN(initN), .selectInN(selectInN), .ackN(ackN), .busy(busy),
    .paperError(paperError), .select(1'b1), .faultN(faultN));
  ecp_periph_model periph_u (.clock(clock), .pdOut(pdOut_r), .pdOeN(pdOeN), .strobeN(strobeN), .autoFdN(autoFdN),
    .initN(initN), .selectInN(selectInN), .pdIn(pdIn), .ackN(ackN), .busy(busy), .paperError(paperError),
    .slow(slow), .gotValid(gotValid), .gotWord(gotWord));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    ioAddr <= a;
    ioWdata <= d;
    ioWr <= w;
    ioRd <= !w;
    @(posedge clock);
    ioWr <= 1'b0;
    ioRd <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    expRd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic drain();
    for (k = 0; k < 3000 && expFwd.size() > 0; k++) @(posedge clock);
  endtask
  // result watcher and hang guard
  always @(posedge clock) begin
    rdSeen <= ioRd;
    if (rdSeen) chk({1'b0, ioRdata_r}, {1'b0, expRd.pop_front()});
    if (gotValid) chk(gotWord, expFwd.pop_front());
    cycles++;
    if (cycles > 30000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {reset, ioWr, ioRd, dmaAckN, faultN, rdSeen} = 6'b100110;
    {ioAddr, ioWdata, irqSelect, dmaSelect, slow} = '0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(11'h402, 8'h15);
    rd(11'h003, 8'h00);
    bus(1'b1, 11'h002, 8'h0a);
    @(posedge clock);
    chk({strobeN, autoFdN, initN, selectInN}, 9'h008);
    rd(11'h002, 8'h0a);
    bus(1'b1, 11'h000, 8'ha7);
    rd(11'h000, 8'ha7);
    bus(1'b1, 11'h002, 8'h04);
    b = rnd();
    irqSelect <= b[5:3];
    dmaSelect <= b[2:0];
    bus(1'b1, 11'h402, 8'he4);
    bus(1'b1, 11'h401, 8'hff);
    rd(11'h401, {2'b00, b[5:0]});
    rd(11'h400, 8'h10);
    rd(11'h001, 8'hf8);
    bus(1'b1, 11'h402, 8'hd4);
    for (i = 0; i < 17; i++) begin
      b = rnd();
      if (i < 16) mem[i] = b;
      dmaAckN <= i[0];
      bus(1'b1, 11'h400, b);
    end
    dmaAckN <= 1'b1;
    rd(11'h402, 8'hd6);
    for (i = 0; i < 16; i++) rd(11'h400, mem[i]);
    rd(11'h402, 8'hd5);
    foreach (md[j]) begin
      bus(1'b1, 11'h402, md[j]);
      for (i = 0; i < 12; i++) begin
        b = rnd();
        slow <= b[1:0];
        expFwd.push_back({i[0] & j[0], b});
        bus(1'b1, (i[0] & j[0]) ? 11'h000 : 11'h400, b);
      end
      drain();
    end
    bus(1'b1, 11'h402, 8'h68);
    @(posedge clock);
    chk(dmaReq, 1'b1);
    dmaAckN <= 1'b0;
    b = rnd();
    expFwd.push_back({1'b0, b});
    bus(1'b1, 11'h002, b);
    dmaAckN <= 1'b1;
    drain();
    faultN <= 1'b0;
    repeat (6) @(posedge clock);
    chk(irqLine, 1'b1);
    faultN <= 1'b1;
    bus(1'b1, 11'h402, 8'h74);
    @(posedge clock);
    chk(irqLine, 1'b0);
    periph_u.revQ = '{9'h011, 9'h103, 9'h0c4, 9'h185};
    bus(1'b1, 11'h002, 8'h24);
    for (k = 0; k < 3000 && (periph_u.revQ.size() > 0 || !ackN); k++) @(posedge clock);
    repeat (20) @(posedge clock);
    rd(11'h400, 8'h11);
    for (i = 0; i < 4; i++) rd(11'h400, 8'hc4);
    rd(11'h400, 8'h85);
    rd(11'h402, 8'h75);
    bus(1'b1, 11'h002, 8'h04);
    for (k = 0; k < 100 && pdOeN !== 1'b0; k++) @(posedge clock);
    chk(pdOeN, 1'b0);
    give_verdict();
  end
endmodule

// file: logic/ecp_defines.vh
// ecp_defines.vh - constants for the extended capabilities parallel port
// assumes it is included by bare name from every design file of the port
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH
// port word and fifo shape
`define ECP_WORD_W 8
`define ECP_FIFO_W 9
`define ECP_FIFO_DEPTH 16
`define ECP_FIFO_AW 4
`define ECP_CNT_W 5
// register offsets from the port base
`define ECP_ADDR_W 11
`define ECP_OFS_DATA 11'h000
`define ECP_OFS_STATUS 11'h001
`define ECP_OFS_CONTROL 11'h002
`define ECP_OFS_FIFO 11'h400
`define ECP_OFS_CFGB 11'h401
`define ECP_OFS_EXTCTL 11'h402
// mode field of the extended control register
`define ECP_MODE_STD 3'h0
`define ECP_MODE_BYTE 3'h1
`define ECP_MODE_FIFO 3'h2
`define ECP_MODE_ECP 3'h3
`define ECP_MODE_EPP 3'h4
`define ECP_MODE_RSVD 3'h5
`define ECP_MODE_TEST 3'h6
`define ECP_MODE_CFG 3'h7
// field positions
`define ECP_CTL_DIR 5
`define ECP_CTL_ACKIE 4
`define ECP_CTL_SELIN 3
`define ECP_CTL_INIT 2
`define ECP_CTL_AUTOFD 1
`define ECP_CTL_STROBE 0
`define ECP_EXT_FAULTDIS 4
`define ECP_EXT_DMA_ENABLE_BIT 3
`define ECP_EXT_SVC 2
// reset values and fixed read values
`define ECP_CONTROL_RST 6'h00
`define ECP_MODE_RST 3'h0
`define ECP_EXTBITS_RST 3'h5
`define ECP_DATA_RST 8'h00
`define ECP_CFGA_VAL 8'h10
`define ECP_UNMAPPED_VAL 8'h00
`endif

// file: logic/ecp_fifo_mem.v
// ecp_fifo_mem.v - 16 entry storage shared by every fifo view of the port
// assumes the caller keeps pointers, counts and full/empty itself
`timescale 1ns/100ps
`include "ecp_defines.vh"
module ecp_fifo_mem (
  // clock
  input wire clock,
  // write side
  input wire wrEn,
  input wire [`ECP_FIFO_AW-1:0] wrAddr,
  input wire [`ECP_FIFO_W-1:0] wrData,
  // read side, data one cycle after the address
  input wire [`ECP_FIFO_AW-1:0] rdAddr,
  output reg [`ECP_FIFO_W-1:0] rdData
);
  reg [`ECP_FIFO_W-1:0] mem [0:`ECP_FIFO_DEPTH-1];

  always @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// file: logic/ecp_parallel_port.v
// ecp_parallel_port.v - extended capabilities parallel port, host side
// assumes host strobes and dma acknowledge are on clock; all pins are asynchronous
`timescale 1ns/100ps
`include "ecp_defines.vh"
module ecp_parallel_port (
  // clock and reset
  input wire clock,
  input wire reset,
  // host register port
  input wire [`ECP_ADDR_W-1:0] ioAddr,
  input wire ioWr,
  input wire ioRd,
  input wire [7:0] ioWdata,
  output reg [7:0] ioRdata_r,
  // dma
  output wire dmaReq,
  input wire dmaAckN,
  // chip level configuration
  input wire [2:0] irqSelect,
  input wire [2:0] dmaSelect,
  output wire irqLine,
  // parallel data pins
  input wire [7:0] pdIn,
  output reg [7:0] pdOut_r,
  output wire pdOeN,
  // control pins
  output wire strobeN,
  output wire autoFdN,
  output wire initN,
  output wire selectInN,
  // status pins
  input wire ackN,
  input wire busy,
  input wire paperError,
  input wire select,
  input wire faultN
);
  localparam S_IDLE = 3'h0;
  localparam S_FSETUP = 3'h1;
  localparam S_FSTB = 3'h2;
  localparam S_FREL = 3'h3;
  localparam S_RREQ = 3'h4;
  localparam S_RACK = 3'h5;
  localparam S_REP = 3'h6;

  // pin synchronisers: stage one only feeds stage two
  wire [12:0] pinRaw = {faultN, select, paperError, busy, ackN, pdIn};
  reg [12:0] pinMeta_r;
  reg [12:0] pinSync_r;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pinMeta_r <= 13'h1fff;
      pinSync_r <= 13'h1fff;
    end else begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end
  wire [7:0] pdS = pinSync_r[7:0];
  wire ackS = pinSync_r[8];
  wire busyS = pinSync_r[9];
  wire pErrS = pinSync_r[10];
  wire selS = pinSync_r[11];
  wire faultS = pinSync_r[12];

  function [2:0] regSel;
    input [`ECP_ADDR_W-1:0] a;
    begin
      case (a)
        `ECP_OFS_DATA: regSel = 3'h1;
        `ECP_OFS_STATUS: regSel = 3'h2;
        `ECP_OFS_CONTROL: regSel = 3'h3;
        `ECP_OFS_FIFO: regSel = 3'h4;
        `ECP_OFS_CFGB: regSel = 3'h5;
        `ECP_OFS_EXTCTL: regSel = 3'h6;
        default: regSel = 3'h0;
      endcase
    end
  endfunction

  // registers
  reg [7:0] dataLatch_r;
  reg [5:0] control_r;
  reg [2:0] mode_r;
  reg [2:0] extBits_r;
  reg faultIrq_r;
  reg faultPrev_r;
  reg [2:0] state_r;
  reg cmdOut_r;
  reg strobeOut_r;
  reg autoFdOut_r;
  reg initOut_r;
  reg drive_r;
  reg [7:0] revByte_r;
  reg revCmd_r;
  reg rleArmed_r;
  reg [6:0] runLen_r;
  reg [6:0] repLeft_r;
  reg [`ECP_FIFO_AW-1:0] wrPtr_r;
  reg [`ECP_FIFO_AW-1:0] rdPtr_r;
  reg [`ECP_CNT_W-1:0] count_r;
  reg stable_r;
  wire [`ECP_FIFO_W-1:0] fifoHead;

  wire modeEcp = (mode_r == `ECP_MODE_ECP);
  wire modeFifo = (mode_r == `ECP_MODE_FIFO);
  wire modeTest = (mode_r == `ECP_MODE_TEST);
  wire modeCfg = (mode_r == `ECP_MODE_CFG);
  wire fifoView = modeFifo | modeEcp | modeTest;
  wire fifoFull = (count_r == `ECP_FIFO_DEPTH);
  wire fifoEmpty = (count_r == 5'h00);
  wire headOk = ~fifoEmpty & stable_r;
  wire dirRev = control_r[`ECP_CTL_DIR];
  wire faultDis = extBits_r[2];
  wire dma_enable_bit = extBits_r[1];
  wire svcBit = extBits_r[0];
  wire revOk = modeEcp & ~initOut_r & ~pErrS & ~drive_r;
  wire fwdOk = modeFifo | (modeEcp & ~dirRev & initOut_r & pErrS & drive_r);

  // host access decode, dma acknowledge steers to the data fifo view
  wire dmaCyc = ~dmaAckN & fifoView;
  wire [2:0] sel = dmaCyc ? 3'h4 : regSel(ioAddr);
  wire hostPush = ioWr & ~fifoFull & ((sel == 3'h4 & fifoView) | (sel == 3'h1 & modeEcp));
  wire hostPop = ioRd & headOk & sel == 3'h4 & fifoView;
  wire [`ECP_FIFO_W-1:0] hostWord = {(sel == 3'h1), ioWdata};

  // engine strobes, set in the fsm below
  reg engPush;
  reg engPop;
  reg [`ECP_FIFO_W-1:0] engWord;
  wire pushEn = engPush | (hostPush & ~(modeEcp & dirRev));
  wire popEn = engPop | (hostPop & ~engPop);
  wire [`ECP_FIFO_W-1:0] pushWord = engPush ? engWord : hostWord;
  wire flush = ~fifoView;

  // shared fifo storage for every view
  ecp_fifo_mem fifoMem (
    .clock(clock),
    .wrEn(pushEn),
    .wrAddr(wrPtr_r),
    .wrData(pushWord),
    .rdAddr(rdPtr_r),
    .rdData(fifoHead)
  );

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPtr_r <= 4'h0;
      rdPtr_r <= 4'h0;
      count_r <= 5'h00;
      stable_r <= 1'b0;
    end else if (flush) begin
      wrPtr_r <= 4'h0;
      rdPtr_r <= 4'h0;
      count_r <= 5'h00;
      stable_r <= 1'b0;
    end else begin
      stable_r <= ~(pushEn | popEn);
      if (pushEn) begin
        wrPtr_r <= wrPtr_r + 4'h1;
      end
      if (popEn) begin
        rdPtr_r <= rdPtr_r + 4'h1;
      end
      if (pushEn & ~popEn) begin
        count_r <= count_r + 5'h01;
      end else if (popEn & ~pushEn) begin
        count_r <= count_r - 5'h01;
      end
    end
  end

  // host writes; control and extended control decode ignores the mode
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      dataLatch_r <= `ECP_DATA_RST;
      control_r <= `ECP_CONTROL_RST;
      mode_r <= `ECP_MODE_RST;
      extBits_r <= `ECP_EXTBITS_RST;
    end else if (ioWr) begin
      if (sel == 3'h1 & ~dmaCyc & (mode_r == `ECP_MODE_STD | mode_r == `ECP_MODE_BYTE)) begin
        dataLatch_r <= ioWdata;
      end
      if (sel == 3'h3) begin
        control_r <= ioWdata[5:0];
      end
      if (sel == 3'h6) begin
        mode_r <= ioWdata[7:5];
        extBits_r <= ioWdata[4:2];
      end
    end
  end

  // fault edge interrupt, masked by faultDis and in ecp reverse; set wins over clear
  wire faultFall = faultPrev_r & ~faultS;
  wire faultSet = faultFall & ~faultDis & ~(modeEcp & dirRev);
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      faultPrev_r <= 1'b1;
      faultIrq_r <= 1'b0;
    end else begin
      faultPrev_r <= faultS;
      if (faultSet) begin
        faultIrq_r <= 1'b1;
      end else if (ioWr & sel == 3'h6) begin
        faultIrq_r <= 1'b0;
      end
    end
  end
  assign irqLine = faultIrq_r | (control_r[`ECP_CTL_ACKIE] & ~ackS);

  // register reads, one word per access
  wire [7:0] statusWord = {~busyS, ackS, pErrS, selS, faultS, 3'h0};
  wire [7:0] cfgBWord = {1'b0, irqLine, irqSelect, dmaSelect};
  wire [7:0] extWord = {mode_r, extBits_r, fifoFull, fifoEmpty};
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ioRdata_r <= `ECP_UNMAPPED_VAL;
    end else if (ioRd) begin
      case (sel)
        3'h1: ioRdata_r <= drive_r ? dataLatch_r : pdS;
        3'h2: ioRdata_r <= statusWord;
        3'h3: ioRdata_r <= {2'h0, control_r};
        3'h4: ioRdata_r <= modeCfg ? `ECP_CFGA_VAL : (fifoView ? fifoHead[7:0] : `ECP_UNMAPPED_VAL);
        3'h5: ioRdata_r <= modeCfg ? cfgBWord : `ECP_UNMAPPED_VAL;
        3'h6: ioRdata_r <= extWord;
        default: ioRdata_r <= `ECP_UNMAPPED_VAL;
      endcase
    end
  end

  // dma request follows direction and fifo room
  assign dmaReq = dma_enable_bit & ~svcBit & (modeFifo | modeEcp) & ((modeEcp & dirRev) ? headOk : ~fifoFull);

  // direction change on init, handed over only on perror
  // a fault request never turns the link round by itself
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      initOut_r <= 1'b1;
      drive_r <= 1'b1;
    end else if (modeEcp) begin
      if (dirRev & state_r == S_IDLE & fifoEmpty) begin
        drive_r <= 1'b0;
        if (~drive_r) begin
          initOut_r <= 1'b0;
        end
      end else if (~dirRev & state_r == S_IDLE) begin
        initOut_r <= 1'b1;
        if (initOut_r & pErrS) begin
          drive_r <= 1'b1;
        end
      end
    end else begin
      initOut_r <= control_r[`ECP_CTL_INIT];
      drive_r <= ~(mode_r == `ECP_MODE_BYTE & dirRev);
    end
  end

  // link engine
  reg [2:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    engPush = 1'b0;
    engPop = 1'b0;
    engWord = {revCmd_r, revByte_r};
    case (state_r)
      S_IDLE: begin
        if (fwdOk & headOk) begin
          engPop = 1'b1;
          state_nxt = S_FSETUP;
        end else if (revOk & dirRev & ~fifoFull & stable_r) begin
          state_nxt = S_RREQ;
        end
      end
      S_FSETUP: begin
        if (~busyS) begin
          state_nxt = S_FSTB;
        end
      end
      S_FSTB: begin
        if (busyS) begin
          state_nxt = S_FREL;
        end
      end
      S_FREL: state_nxt = S_IDLE;
      S_RREQ: begin
        if (~ackS) begin
          state_nxt = S_RACK;
        end else if (~dirRev) begin
          state_nxt = S_IDLE;
        end
      end
      S_RACK: begin
        if (ackS) begin
          if (revCmd_r & ~revByte_r[7]) begin
            state_nxt = S_IDLE;
          end else begin
            engPush = 1'b1;
            state_nxt = (rleArmed_r & runLen_r != 7'h00) ? S_REP : S_IDLE;
          end
        end
      end
      S_REP: begin
        if (~fifoFull) begin
          engPush = 1'b1;
          if (repLeft_r == 7'h01) begin
            state_nxt = S_IDLE;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      pdOut_r <= `ECP_DATA_RST;
      cmdOut_r <= 1'b0;
      strobeOut_r <= 1'b1;
      autoFdOut_r <= 1'b1;
      revByte_r <= 8'h00;
      revCmd_r <= 1'b0;
      rleArmed_r <= 1'b0;
      runLen_r <= 7'h00;
      repLeft_r <= 7'h00;
    end else begin
      state_r <= (fwdOk | revOk | state_r == S_REP) ? state_nxt : S_IDLE;
      if (~(modeEcp | modeFifo)) begin
        pdOut_r <= dataLatch_r;
      end
      case (state_r)
        S_IDLE: begin
          strobeOut_r <= 1'b1;
          autoFdOut_r <= 1'b1;
          if (~modeEcp) begin
            rleArmed_r <= 1'b0;
          end
          if (state_nxt == S_FSETUP) begin
            pdOut_r <= fifoHead[7:0];
            cmdOut_r <= fifoHead[8] & modeEcp;
          end
          if (state_nxt == S_RREQ) begin
            autoFdOut_r <= 1'b0;
          end
        end
        S_FSETUP: begin
          if (state_nxt == S_FSTB) begin
            strobeOut_r <= 1'b0;
          end
        end
        S_FSTB: begin
          if (state_nxt == S_FREL) begin
            strobeOut_r <= 1'b1;
          end
        end
        S_RREQ: begin
          if (state_nxt == S_RACK) begin
            revByte_r <= pdS;
            revCmd_r <= ~busyS;
            autoFdOut_r <= 1'b1;
          end
        end
        S_RACK: begin
          if (ackS) begin
            if (revCmd_r & ~revByte_r[7]) begin
              rleArmed_r <= 1'b1;
              runLen_r <= revByte_r[6:0];
            end else begin
              rleArmed_r <= 1'b0;
              repLeft_r <= rleArmed_r ? runLen_r : 7'h00;
            end
          end
        end
        S_REP: begin
          if (engPush) begin
            repLeft_r <= repLeft_r - 7'h01;
          end
        end
        default: begin
          strobeOut_r <= 1'b1;
        end
      endcase
    end
  end

  // pin drive; standard modes follow the control register
  wire hwLink = modeEcp | modeFifo;
  assign strobeN = hwLink ? strobeOut_r : ~control_r[`ECP_CTL_STROBE];
  assign autoFdN = modeEcp ? (dirRev ? autoFdOut_r : ~cmdOut_r) : ~control_r[`ECP_CTL_AUTOFD];
  assign initN = initOut_r;
  assign selectInN = modeEcp ? 1'b1 : ~control_r[`ECP_CTL_SELIN];
  assign pdOeN = ~drive_r;
endmodule
